// ### sctrim_divider.sv
// glitch-free power-of-two clock enable divider
// assumes select changes arrive from logic on the same clock
`timescale 1ns/10ps
module sctrim_divider
(
   input  wire logic       ref_clk_i,
   input  wire logic       resetn_i,
   input  wire logic [3:0] select_i,
   output logic            tick_o
);

   // ----------------------------------------------------------------
   // count state, never visible to software
   // ----------------------------------------------------------------
   logic [sctrim_pkg::DIV_CNT_W-1:0] cnt_r;
   logic [3:0]                       act_sel_r;
   logic                             tick_r;
   logic [sctrim_pkg::DIV_CNT_W-1:0] mask;
   logic                             wrap;
   logic [3:0]                       eff_sel;

   // reserved codes fall back to the slowest rate, never faster
   assign eff_sel = (select_i > sctrim_pkg::SEL_MAX) ? sctrim_pkg::SEL_MAX : select_i;
   assign mask    = sctrim_pkg::DIV_CNT_W'((9'h001 << act_sel_r) - 9'h001);
   assign wrap    = ((cnt_r & mask) == mask);

   // new setting only at a boundary of the old period; the counter restarts
   // so the first new period is whole: no short pulse in between  // see [RL1]
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         cnt_r     <= '0;
         act_sel_r <= sctrim_pkg::SEL_RESET_UNPROG;
         tick_r    <= 1'b0;
      end
      else if (wrap)
      begin
         cnt_r     <= '0;                 // see [RL2]
         act_sel_r <= eff_sel;            // see [RL3]
         tick_r    <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 1'b1;          // see [RL2]
         tick_r <= 1'b0;
      end
   end

   assign tick_o = tick_r;

endmodule // sctrim_divider

// ### sctrim_pkg.sv
// package for the system clock prescaler and rc oscillator trim block
// assumes a single 40 MHz block clock and an axi4-lite register master
package sctrim_pkg;

   // ----------------------------------------------------------------
   // register map (index = printed offset, byte address = 4 * index)
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W          = 12;
   localparam logic [7:0]  DIVCTL_IDX      = 8'h61;
   localparam logic [7:0]  TRIM_IDX        = 8'h66;
   localparam logic [ADDR_W-1:0] DIVCTL_ADDR = {2'h0, DIVCTL_IDX, 2'h0};
   localparam logic [ADDR_W-1:0] TRIM_ADDR   = {2'h0, TRIM_IDX, 2'h0};

   // ----------------------------------------------------------------
   // divider control and oscillator trim fields
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       change_enable;
      logic [2:0] reserved;
      logic [3:0] divider_select;
   } sctrim_divctl_t;

   typedef struct packed {
      logic       trim_range_bit;
      logic [6:0] trim_fine_bits;
   } sctrim_trim_t;

   localparam logic [3:0] SEL_RESET_UNPROG = 4'h0;
   localparam logic [3:0] SEL_RESET_FUSE   = 4'h3;
   localparam logic [3:0] SEL_MAX          = 4'h8;
   localparam logic [7:0] TRIM_RESET       = 8'h00;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam logic [2:0] CE_WINDOW        = 3'h4;
   localparam logic [1:0] SYNC_FILL        = 2'h3;
   localparam int unsigned DIV_CNT_W       = 8;

   // ----------------------------------------------------------------
   // bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

endpackage

// ### sctrim_tb_top.sv
// self-checking bench for the prescaler/trim block
// assumes the monitor is bound in, 40 MHz clock
`timescale 1ns/10ps
module sctrim_tb_top;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                          ref_clk_i, resetn_i = 1'b0, divide_by_eight_fuse_i = 1'b0;
   logic [7:0]                    factory_trim_i = 8'h5A;
   logic [sctrim_pkg::ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0]                   s_axi_wdata = '0, s_axi_rdata, rd;
   logic [3:0]                    s_axi_wstrb = 4'hF;
   logic [1:0]                    s_axi_bresp, s_axi_rresp, rsp;
   logic                          s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                          s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic                          s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic                          sys_clk_en_o, trim_range_o;
   logic [6:0]                    trim_fine_o;
   logic [7:0]                    tv;
   int                            errors = 0, n_compared = 0, gap, last_gap, min_gap = 1, old, np;
   localparam logic [11:0] DA = sctrim_pkg::DIVCTL_ADDR;
   localparam logic [11:0] TA = sctrim_pkg::TRIM_ADDR;

   sctrim_top dut_u (.ref_clk_i, .resetn_i, .divide_by_eight_fuse_i, .factory_trim_i,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sys_clk_en_o,
      .trim_range_o, .trim_fine_o);

   initial
   begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // ----------------------------------------------------------------
   // divided period watch: no gap below min_gap
   // ----------------------------------------------------------------
   always @(posedge ref_clk_i or negedge resetn_i)
      if (!resetn_i)
         gap <= 0;
      else if (sys_clk_en_o)
      begin
         if (gap != 0 && gap < min_gap)
         begin
            errors++;
            $display("BAD %0t gap %0h min %0h", $time, gap, min_gap);
         end
         last_gap <= gap;
         gap      <= 1;
      end
      else if (gap != 0)
         gap <= gap + 1;

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         errors++;
         $display("BAD %0t got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic aw, w;
      @(posedge ref_clk_i);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      aw = 1'b1;
      w  = 1'b1;
      while (aw || w)
      begin
         @(posedge ref_clk_i);
         if (aw && s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (w && s_axi_wready)
            s_axi_wvalid <= 1'b0;
         aw = aw && !s_axi_awready;
         w  = w && !s_axi_wready;
      end
      do @(posedge ref_clk_i); while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd_reg(input logic [11:0] a);
      @(posedge ref_clk_i);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge ref_clk_i); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge ref_clk_i); while (!s_axi_rvalid);
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
      rd_reg(a);
      chk(rd, exp);
   endtask

   task automatic rst(input logic f);
      min_gap                <= 1;
      divide_by_eight_fuse_i <= f;
      resetn_i               <= 1'b0;
      repeat (20) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      repeat (30) @(posedge ref_clk_i);
   endtask

   task automatic wrap_up;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // tests
   // ----------------------------------------------------------------
   initial
   begin
      rst(1'b0);
      rchk(DA, 32'h0);
      rchk(TA, 32'h5A);
      chk({24'h0, trim_range_o, trim_fine_o}, 32'h5A);
      factory_trim_i <= 8'hC3;
      rst(1'b1);
      rchk(DA, 32'h3);
      chk(32'(rsp), 32'(sctrim_pkg::RESP_OKAY));
      rchk(TA, 32'hC3);
      chk(32'(last_gap), 32'h8);
      wr(DA, 8'h81);
      wr(DA, 8'h00);
      rchk(DA, 32'h3);
      wr(DA, 8'h80);
      repeat (6) @(posedge ref_clk_i);
      wr(DA, 8'h01);
      rchk(DA, 32'h3);
      wr(DA, 8'h80);
      wr(DA, 8'h80);
      wr(DA, 8'h01);
      rchk(DA, 32'h3);
      // every code 0-8 plus reserved 9; window needs back-to-back writes
      old = 8;
      for (int c = 0; c < 10; c++)
      begin
         np = (c > 8) ? 256 : (1 << c);
         min_gap <= (np < old) ? np : old;
         wr(DA, 8'h80);
         wr(DA, {4'h0, 4'(c)});
         repeat (old + 2 * np + 4) @(posedge ref_clk_i);
         min_gap <= np;
         chk(32'(last_gap), 32'(np));
         rchk(DA, 32'(c));
         old = np;
      end
      wr(DA, 8'h80);
      wr(DA, 8'h72);
      chk(32'(rsp), 32'(sctrim_pkg::RESP_OKAY));
      rchk(DA, 32'h2);
      // no flash or eeprom writes run here, so any trim is safe
      for (int i = 0; i < 2; i++)
      begin
         tv = i ? 8'h80 : 8'h7F;
         wr(TA, tv);
         repeat (2) @(posedge ref_clk_i);
         chk({24'h0, trim_range_o, trim_fine_o}, {24'h0, tv});
         rchk(TA, {24'h0, tv});
      end
      s_axi_wstrb <= 4'hE;
      wr(TA, 8'h11);
      s_axi_wstrb <= 4'hF;
      rchk(TA, 32'h80);
      wr(12'h010, 8'h55);
      chk(32'(rsp), 32'(sctrim_pkg::RESP_SLVERR));
      rchk(12'h010, 32'h0);
      chk(32'(rsp), 32'(sctrim_pkg::RESP_SLVERR));
      wrap_up();
   end

   // hang guard, well beyond the few thousand cycles the tests take
   initial
   begin
      #500000;
      errors++;
      wrap_up();
   end
endmodule // sctrim_tb_top

// ### sctrim_top.sv
// system clock prescaler and rc oscillator trim, axi4-lite slave
// assumes fuse and factory trim are static straps from outside the clock domain
//
// Notes on behaviour
// [RL1] divider switches without glitch or faster period
// [RL2] counter runs on source clock, hidden
// [RL3] new rate after old then new period
// [RL4] software first writes change-enable alone
// [RL5] software writes select within four cycles
// [RL6] software keeps interrupts off during sequence
// [RL7] change-enable updates only with others zero
// [RL8] change-enable clears after four cycles or write
// [RL9] rewriting change-enable neither restarts nor clears
// [RL10] select is power-of-two factor, codes 9-15 reserved
// [RL11] reset select from divide-by-eight fuse
// [RL12] any select writable regardless of fuse
// [RL13] divided enable paces cpu and peripherals
// [RL14] trim loads factory value at reset
// [RL15] trim writes steer oscillator frequency
// [RL16] trim top bit selects overlapping range
// [RL17] lower trim bits tune monotonically
// [RL18] software avoids trim above 8.8 MHz when writing
// [RL19] divider bits six to four read zero
`timescale 1ns/10ps
module sctrim_top
(
   input  wire logic                          ref_clk_i,
   input  wire logic                          resetn_i,
   // straps
   input  wire logic                          divide_by_eight_fuse_i,
   input  wire logic [7:0]                    factory_trim_i,
   // axi4-lite
   input  wire logic [sctrim_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [31:0]                   s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [sctrim_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [31:0]                        s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   // clock system
   output logic                               sys_clk_en_o,
   output logic                               trim_range_o,
   output logic [6:0]                         trim_fine_o
);

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic logic reg_hit(input logic [sctrim_pkg::ADDR_W-1:0] addr,
                                    input logic [sctrim_pkg::ADDR_W-1:0] base);
      reg_hit = (addr[sctrim_pkg::ADDR_W-1:2] == base[sctrim_pkg::ADDR_W-1:2]);
   endfunction

   // ----------------------------------------------------------------
   // strap capture: three stages, accepted when stages two and three agree
   // ----------------------------------------------------------------
   logic [8:0] strap_s1_r;
   logic [8:0] strap_s2_r;
   logic [8:0] strap_s3_r;
   logic [1:0] fill_r;
   logic       init_done_r;
   logic       strap_ok;

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         strap_s1_r <= '0;
         strap_s2_r <= '0;
         strap_s3_r <= '0;
      end
      else
      begin
         strap_s1_r <= {divide_by_eight_fuse_i, factory_trim_i};
         strap_s2_r <= strap_s1_r;
         strap_s3_r <= strap_s2_r;
      end
   end

   // straps that keep toggling hold off init rather than load a torn value
   assign strap_ok = (fill_r == sctrim_pkg::SYNC_FILL) && (strap_s2_r == strap_s3_r);

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         fill_r <= '0;
      end
      else if (fill_r != sctrim_pkg::SYNC_FILL)
      begin
         fill_r <= fill_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // axi write channel
   // ----------------------------------------------------------------
   logic                          awready_r;
   logic                          wready_r;
   logic                          bvalid_r;
   logic [1:0]                    bresp_r;
   logic                          aw_have_r;
   logic                          w_have_r;
   logic [sctrim_pkg::ADDR_W-1:0] awaddr_r;
   logic [7:0]                    wbyte_r;
   logic                          wlane_r;
   logic                          aw_hs;
   logic                          w_hs;
   logic                          wr_go;
   logic                          wr_div;
   logic                          wr_trim;

   assign aw_hs   = s_axi_awvalid && awready_r;
   assign w_hs    = s_axi_wvalid && wready_r;
   assign wr_go   = aw_have_r && w_have_r && !bvalid_r;
   // a write without byte lane 0 is still answered but changes nothing
   assign wr_div  = wr_go && wlane_r && reg_hit(awaddr_r, sctrim_pkg::DIVCTL_ADDR);
   assign wr_trim = wr_go && wlane_r && reg_hit(awaddr_r, sctrim_pkg::TRIM_ADDR);

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         awready_r <= 1'b0;
         wready_r  <= 1'b0;
         aw_have_r <= 1'b0;
         w_have_r  <= 1'b0;
         awaddr_r  <= '0;
         wbyte_r   <= '0;
         wlane_r   <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= sctrim_pkg::RESP_OKAY;
      end
      else
      begin
         if (init_done_r && !aw_have_r && !bvalid_r && !aw_hs)
         begin
            awready_r <= 1'b1;
         end
         else if (aw_hs)
         begin
            awready_r <= 1'b0;
         end
         if (init_done_r && !w_have_r && !bvalid_r && !w_hs)
         begin
            wready_r <= 1'b1;
         end
         else if (w_hs)
         begin
            wready_r <= 1'b0;
         end
         if (aw_hs)
         begin
            aw_have_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (w_hs)
         begin
            w_have_r <= 1'b1;
            wbyte_r  <= s_axi_wdata[7:0];
            wlane_r  <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (reg_hit(awaddr_r, sctrim_pkg::DIVCTL_ADDR) || reg_hit(awaddr_r, sctrim_pkg::TRIM_ADDR))
                         ? sctrim_pkg::RESP_OKAY : sctrim_pkg::RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready)
         begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // divider control register
   // ----------------------------------------------------------------
   sctrim_pkg::sctrim_divctl_t wdiv;
   logic                       ce_r;
   logic [2:0]                 ce_cnt_r;
   logic [3:0]                 sel_r;
   logic                       ce_set;
   logic                       sel_write;
   logic                       ce_expire;

   assign wdiv      = sctrim_pkg::sctrim_divctl_t'(wbyte_r);
   // enable only sets when every other bit is written zero  // see [RL7]
   assign ce_set    = wr_div && wdiv.change_enable && (wdiv.reserved == 3'h0) && (wdiv.divider_select == 4'h0);
   // the second step must carry a zero enable and find the window open  // see [RL4] [RL5]
   assign sel_write = wr_div && !wdiv.change_enable && ce_r;
   assign ce_expire = ce_r && (ce_cnt_r == 3'h1);

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         ce_r     <= 1'b0;
         ce_cnt_r <= '0;
      end
      else if (sel_write || ce_expire)
      begin
         ce_r     <= 1'b0;                // see [RL8]
         ce_cnt_r <= '0;
      end
      else if (ce_set && !ce_r)
      begin
         ce_r     <= 1'b1;
         ce_cnt_r <= sctrim_pkg::CE_WINDOW;
      end
      else if (ce_r)
      begin
         ce_cnt_r <= ce_cnt_r - 1'b1;     // a repeat set leaves the count alone  // see [RL9]
      end
   end

   // fuse sets only the starting value; later writes take any code  // see [RL11] [RL12]
   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sel_r <= sctrim_pkg::SEL_RESET_UNPROG;
      end
      else if (!init_done_r && strap_ok)
      begin
         sel_r <= strap_s3_r[8] ? sctrim_pkg::SEL_RESET_FUSE : sctrim_pkg::SEL_RESET_UNPROG; // see [RL11]
      end
      else if (sel_write)
      begin
         sel_r <= wdiv.divider_select;    // see [RL12]
      end
   end

   // ----------------------------------------------------------------
   // oscillator trim register
   // ----------------------------------------------------------------
   sctrim_pkg::sctrim_trim_t trim_r;

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         trim_r      <= sctrim_pkg::TRIM_RESET;
         init_done_r <= 1'b0;
      end
      else if (!init_done_r && strap_ok)
      begin
         trim_r      <= sctrim_pkg::sctrim_trim_t'(strap_s3_r[7:0]);  // see [RL14]
         init_done_r <= 1'b1;
      end
      else if (wr_trim)
      begin
         trim_r <= sctrim_pkg::sctrim_trim_t'(wbyte_r);               // see [RL15]
      end
   end

   // range bit and fine bits go out unchanged to the oscillator  // see [RL16] [RL17]
   assign trim_range_o = trim_r.trim_range_bit;
   assign trim_fine_o  = trim_r.trim_fine_bits;

   // ----------------------------------------------------------------
   // axi read channel
   // ----------------------------------------------------------------
   logic        arready_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   logic        ar_hs;
   logic        rd_div;
   logic        rd_trim;
   logic [31:0] rd_mux;
   sctrim_pkg::sctrim_divctl_t rdiv;

   assign ar_hs   = s_axi_arvalid && arready_r;
   assign rd_div  = reg_hit(s_axi_araddr, sctrim_pkg::DIVCTL_ADDR);
   assign rd_trim = reg_hit(s_axi_araddr, sctrim_pkg::TRIM_ADDR);
   // reserved bits read zero, writes to them are dropped  // see [RL19]
   assign rdiv    = '{change_enable: ce_r, reserved: 3'h0, divider_select: sel_r};
   assign rd_mux  = rd_div  ? {24'h000000, rdiv} :
                    rd_trim ? {24'h000000, trim_r} : 32'h00000000;

   always_ff @(posedge ref_clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= sctrim_pkg::RESP_OKAY;
      end
      else if (ar_hs)
      begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rdata_r   <= rd_mux;
         rresp_r   <= (rd_div || rd_trim) ? sctrim_pkg::RESP_OKAY : sctrim_pkg::RESP_SLVERR;
      end
      else if (rvalid_r && s_axi_rready)
      begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
      else if (init_done_r && !rvalid_r)
      begin
         arready_r <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // divider: its enable paces every synchronous consumer  // see [RL13]
   // ----------------------------------------------------------------
   sctrim_divider u_divider
   (
      .ref_clk_i (ref_clk_i),
      .resetn_i  (resetn_i),
      .select_i  (sel_r),           // see [RL10]
      .tick_o    (sys_clk_en_o)
   );

   assign s_axi_awready = awready_r;
   assign s_axi_wready  = wready_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

endmodule // sctrim_top

// ### sctrim_top_monitor.sv
// bus and trim output checks for the prescaler/trim block
// assumes one clock domain, bound onto every sctrim_top
`timescale 1ns/10ps
module sctrim_top_monitor
(
   input wire logic                          ref_clk_i,
   input wire logic                          resetn_i,
   input wire logic                          s_axi_awvalid,
   input wire logic                          s_axi_awready,
   input wire logic                          s_axi_wvalid,
   input wire logic                          s_axi_wready,
   input wire logic [1:0]                    s_axi_bresp,
   input wire logic                          s_axi_bvalid,
   input wire logic                          s_axi_bready,
   input wire logic [sctrim_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic                          s_axi_arvalid,
   input wire logic                          s_axi_arready,
   input wire logic [31:0]                   s_axi_rdata,
   input wire logic [1:0]                    s_axi_rresp,
   input wire logic                          s_axi_rvalid,
   input wire logic                          s_axi_rready,
   input wire logic                          trim_range_o,
   input wire logic [6:0]                    trim_fine_o
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   logic [sctrim_pkg::ADDR_W-1:0] rd_addr_r;
   logic [3:0]                    up_r;
   wire logic                     rd_mapped;
   wire logic                     rd_div;
   assign rd_div    = rd_addr_r == sctrim_pkg::DIVCTL_ADDR;
   assign rd_mapped = rd_div || (rd_addr_r == sctrim_pkg::TRIM_ADDR);
   // up_r masks the strap load right after reset
   always_ff @(posedge ref_clk_i or negedge resetn_i)
      if (!resetn_i)
      begin
         rd_addr_r <= '0;
         up_r      <= 4'h0;
      end
      else
      begin
         if (s_axi_arvalid && s_axi_arready)
            rd_addr_r <= s_axi_araddr;
         up_r <= up_r + {3'h0, up_r != 4'hF};
      end
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_b_soon;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
   endproperty
   a_b_soon: assert property (p_b_soon) else $error("write answer late");
   property p_r_soon;
      s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
   endproperty
   a_r_soon: assert property (p_r_soon) else $error("read answer late");
   property p_busy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_busy: assert property (p_busy) else $error("write taken while busy");
   property p_hi_zero;
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_hi_zero: assert property (p_hi_zero) else $error("upper read bits set");
   property p_div_rsvd;
      s_axi_rvalid && rd_div |-> s_axi_rdata[6:4] == 3'h0;
   endproperty
   a_div_rsvd: assert property (p_div_rsvd) else $error("reserved bits set");
   property p_unmapped;
      s_axi_rvalid && !rd_mapped |-> s_axi_rresp == sctrim_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
   property p_trim_wr;
      up_r == 4'hF && $changed({trim_range_o, trim_fine_o}) |-> s_axi_bvalid || $past(s_axi_bvalid);
   endproperty
   a_trim_wr: assert property (p_trim_wr) else $error("trim moved without write");
endmodule // sctrim_top_monitor

bind sctrim_top sctrim_top_monitor mon_u (.ref_clk_i, .resetn_i, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
   .trim_range_o, .trim_fine_o);
